// ===== hdlc_packet_transceiver.sv
`timescale 1ns/1ps
`include "hdlc_defines.svh"
module hdlc_packet_transceiver
  import hdlc_pkg::*;
#(
  parameter int FIFO_DEPTH = `HDLC_FIFO_DEPTH,
  parameter int LVL_W      = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire logic      second_packet_controller_select,
  input  wire logic      channel_rate_select,
  input  wire logic      e1_mode,
  input  wire logic      ccs_mode,
  input  wire logic      idle_select_flags,
  input  wire logic      ts16_alarm_detect,
  input  wire logic      ts16_alarm_force_transmit,
  input  wire logic      addr_match_enable,
  input  wire logic      addr_two_byte,
  input  wire logic [7:0] addr_first,
  input  wire logic [7:0] addr_second,
  input  wire logic [2:0] fifo_threshold,
  input  wire logic      chan_strobe,
  input  wire logic [4:0] chan_slot,
  input  wire logic [2:0] chan_bit,
  input  wire logic      chan_rx_bit,
  output      logic      chan_tx_bit,
  output      logic      chan_tx_drive,
  input  wire logic      tx_wr_valid,
  input  wire tx_entry_t tx_wr_entry,
  output      logic      tx_wr_ready,
  output      logic      rx_rd_valid,
  output      rx_entry_t rx_rd_entry,
  input  wire logic      rx_rd_ready,
  output      logic      ts16_alarm_status,
  output      logic      tx_fifo_low,
  output      logic      rx_fifo_high,
  output      logic      tx_underrun,
  output      logic      tx_packet_done,
  output      logic      rx_packet_done,
  output      logic      rx_bad_frame,
  output      logic      rx_overflow,
  output      logic      rx_go_ahead,
  output      logic      rx_idle
);
  if (FIFO_DEPTH < `HDLC_THR_STEP || FIFO_DEPTH % `HDLC_THR_STEP != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a nonzero multiple of 16");
  end

  // ------------------------------------------------------------
  // Channel selection
  // ------------------------------------------------------------
  logic sel;
  logic slot_hit;
  logic force_hit;
  logic bit_step;

  assign sel = second_packet_controller_select;
  // In 56 kb/s mode the last bit of the channel is not ours
  assign slot_hit = sel && (e1_mode ?
      (ccs_mode && chan_slot == `HDLC_E1_SLOT_INDEX) :
      (chan_slot == `HDLC_T1_SLOT_INDEX &&
       (channel_rate_select || chan_bit != `HDLC_RATE56_SKIP_BIT)));
  assign force_hit = e1_mode && ts16_alarm_force_transmit && chan_slot == `HDLC_E1_SLOT_INDEX;
  assign bit_step  = chan_strobe && slot_hit;

  // ------------------------------------------------------------
  // FIFOs and thresholds
  // ------------------------------------------------------------
  logic             tx_q_valid;
  tx_entry_t        tx_q_entry;
  logic             tx_pop;
  logic [LVL_W-1:0] tx_level;
  logic             rx_wr_valid_r;
  rx_entry_t        rx_wr_entry_r;
  logic             rx_wr_ready;
  logic [LVL_W-1:0] rx_level;
  logic [LVL_W-1:0] thr_level;

  hdlc_fifo #(.WIDTH($bits(tx_entry_t)), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_tx_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (tx_wr_valid),
    .in_data   (tx_wr_entry),
    .in_ready  (tx_wr_ready),
    .out_valid (tx_q_valid),
    .out_data  (tx_q_entry),
    .out_ready (tx_pop),
    .level     (tx_level)
  );

  hdlc_fifo #(.WIDTH($bits(rx_entry_t)), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_rx_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (rx_wr_valid_r),
    .in_data   (rx_wr_entry_r),
    .in_ready  (rx_wr_ready),
    .out_valid (rx_rd_valid),
    .out_data  (rx_rd_entry),
    .out_ready (rx_rd_ready),
    .level     (rx_level)
  );

  assign thr_level = LVL_W'((32'(fifo_threshold) + 32'd1) * `HDLC_THR_STEP);

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_fifo_low       <= 1'b0;
      rx_fifo_high      <= 1'b0;
      ts16_alarm_status <= 1'b0;
    end else begin
      tx_fifo_low       <= sel && tx_level <= thr_level;
      rx_fifo_high      <= sel && rx_level >= thr_level;
      ts16_alarm_status <= ts16_alarm_detect;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  tx_state_t   tx_state_r;
  logic [15:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  logic [3:0]  tx_ones_r;
  logic        tx_eop_r;
  logic        tx_fill_flag_r;
  logic        tx_stuff;
  logic        tx_bit;
  logic        tx_last;
  logic        tx_crc_clear;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_nxt;

  // Trailing ones of the check field still owe their zero before the flag
  assign tx_stuff = (tx_state_r == TX_DATA || tx_state_r == TX_FCS ||
                     (tx_state_r == TX_FLAG && tx_cnt_r == 4'h0)) &&
                    tx_ones_r == `HDLC_STUFF_ONES;
  assign tx_bit   = tx_stuff ? 1'b0 : tx_sh_r[0];
  assign tx_last  = !tx_stuff && tx_cnt_r == ((tx_state_r == TX_FCS) ? 4'hF : 4'h7);
  // A packet may start only at a flag boundary or after a fill byte that is a flag
  assign tx_pop   = bit_step && tx_last && tx_q_valid &&
                    ((tx_state_r == TX_DATA && !tx_eop_r) || tx_state_r == TX_FLAG ||
                     (tx_state_r == TX_FILL && tx_fill_flag_r));
  assign tx_crc_clear = tx_pop && tx_state_r != TX_DATA;

  hdlc_crc16 u_tx_crc (
    .clk     (clk),
    .srst    (srst),
    .clear   (tx_crc_clear),
    .step    (bit_step && !tx_stuff && tx_state_r == TX_DATA),
    .din     (tx_sh_r[0]),
    .crc     (tx_crc),
    .crc_nxt (tx_crc_nxt)
  );

  always_ff @(posedge clk) begin
    if (srst || !sel) begin
      tx_state_r     <= TX_FILL;
      tx_sh_r        <= {8'h00, `HDLC_ONES_BYTE};
      tx_cnt_r       <= 4'h0;
      tx_ones_r      <= 4'h0;
      tx_eop_r       <= 1'b0;
      tx_fill_flag_r <= 1'b0;
      tx_underrun    <= 1'b0;
      tx_packet_done <= 1'b0;
    end else begin
      tx_underrun    <= 1'b0;
      tx_packet_done <= 1'b0;
      if (bit_step) begin
        if (tx_stuff) begin
          tx_ones_r <= 4'h0;
        end else begin
          tx_sh_r   <= tx_sh_r >> 1;
          tx_cnt_r  <= tx_cnt_r + 4'h1;
          tx_ones_r <= (tx_sh_r[0] && tx_state_r inside {TX_DATA, TX_FCS}) ?
                       tx_ones_r + 4'h1 : 4'h0;
        end
        if (tx_last) begin
          tx_cnt_r <= 4'h0;
          case (tx_state_r)
            TX_DATA: begin
              if (tx_eop_r) begin
                tx_state_r <= TX_FCS;
                tx_sh_r    <= ~tx_crc_nxt;
              end else if (!tx_q_valid) begin
                tx_state_r  <= TX_ABORT;
                tx_sh_r     <= {8'h00, `HDLC_ABORT_BYTE};
                tx_underrun <= 1'b1;
              end else if (tx_q_entry.abort_tag) begin
                tx_state_r <= TX_ABORT;
                tx_sh_r    <= {8'h00, `HDLC_ABORT_BYTE};
              end else begin
                tx_sh_r  <= {8'h00, tx_q_entry.data};
                tx_eop_r <= tx_q_entry.end_of_packet_tag;
              end
            end
            TX_FCS: begin
              tx_state_r     <= TX_FLAG;
              tx_sh_r        <= {8'h00, `HDLC_FLAG};
              tx_packet_done <= 1'b1;
            end
            TX_FLAG, TX_FILL: begin
              if (tx_q_valid && (tx_state_r == TX_FLAG || tx_fill_flag_r)) begin
                // Closing flag doubles as the next opening flag
                tx_state_r <= tx_q_entry.abort_tag ? TX_ABORT : TX_DATA;
                tx_sh_r    <= {8'h00, tx_q_entry.abort_tag ? `HDLC_ABORT_BYTE
                                                           : tx_q_entry.data};
                tx_eop_r   <= tx_q_entry.end_of_packet_tag;
              end else if (tx_q_valid) begin
                tx_state_r <= TX_FLAG;
                tx_sh_r    <= {8'h00, `HDLC_FLAG};
              end else begin
                tx_state_r     <= TX_FILL;
                tx_fill_flag_r <= idle_select_flags;
                tx_sh_r        <= {8'h00, idle_select_flags ? `HDLC_FLAG : `HDLC_ONES_BYTE};
              end
            end
            default: begin
              tx_state_r     <= TX_FILL;
              tx_fill_flag_r <= idle_select_flags;
              tx_sh_r        <= {8'h00, idle_select_flags ? `HDLC_FLAG : `HDLC_ONES_BYTE};
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chan_tx_bit   <= 1'b1;
      chan_tx_drive <= 1'b0;
    end else if (chan_strobe) begin
      chan_tx_drive <= slot_hit || force_hit;
      chan_tx_bit   <= force_hit ? 1'b1 : tx_bit;
    end else begin
      chan_tx_drive <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic [8:0]  rx_raw_r;
  logic [3:0]  rx_ones_r;
  logic        rx_in_frame_r;
  logic [6:0]  rx_dly_r;
  logic [2:0]  rx_dly_cnt_r;
  logic [15:0] rx_len_r;
  logic [7:0]  rx_asm_r;
  logic [7:0]  rx_b0_r;
  logic [7:0]  rx_b1_r;
  logic [7:0]  rx_b2_r;
  logic [1:0]  rx_nbytes_r;
  logic        rx_first_pend_r;
  logic        rx_drop_r;
  logic [8:0]  raw_nxt;
  logic        rx_flag;
  logic        rx_abort;
  logic        rx_delete;
  logic        rx_exit;
  logic [7:0]  asm_nxt;
  logic        addr_ok;
  logic        rx_crc_ok;
  logic [15:0] rx_crc;

  assign raw_nxt   = {rx_raw_r[7:0], chan_rx_bit};
  assign rx_flag   = raw_nxt[7:0] == `HDLC_FLAG;
  assign rx_abort  = chan_rx_bit && rx_ones_r == `HDLC_ABORT_ONES - 4'h1;
  assign rx_delete = !chan_rx_bit && rx_ones_r == `HDLC_STUFF_ONES;
  // Seven-bit delay keeps the flag's own leading bits out of the data
  assign rx_exit   = rx_in_frame_r && !rx_flag && !rx_abort && !rx_delete &&
                     rx_dly_cnt_r == `HDLC_FLAG_TAIL;
  assign asm_nxt   = {rx_dly_r[6], rx_asm_r[7:1]};
  assign addr_ok   = !addr_match_enable || rx_b2_r == `HDLC_ALL_CALL ||
                     (rx_b2_r == addr_first && (!addr_two_byte || rx_b1_r == addr_second));
  assign rx_crc_ok = rx_crc == `HDLC_CRC_GOOD;

  hdlc_crc16 u_rx_crc (
    .clk     (clk),
    .srst    (srst),
    .clear   (bit_step && rx_flag),
    .step    (bit_step && rx_exit),
    .din     (rx_dly_r[6]),
    .crc     (rx_crc),
    .crc_nxt ()
  );

  always_ff @(posedge clk) begin
    if (srst || !sel) begin
      rx_raw_r      <= '0;
      rx_ones_r     <= 4'h0;
      rx_in_frame_r <= 1'b0;
      rx_dly_cnt_r  <= 3'h0;
      rx_dly_r      <= '0;
      rx_go_ahead   <= 1'b0;
      rx_idle       <= 1'b0;
    end else begin
      rx_go_ahead <= 1'b0;
      if (bit_step) begin
        rx_raw_r  <= raw_nxt;
        rx_ones_r <= !chan_rx_bit ? 4'h0 :
                     (rx_ones_r == `HDLC_IDLE_ONES) ? rx_ones_r : rx_ones_r + 4'h1;
        rx_idle   <= chan_rx_bit && rx_ones_r >= `HDLC_IDLE_ONES - 4'h1;
        rx_go_ahead <= !rx_in_frame_r && raw_nxt == `HDLC_GO_AHEAD;
        if (rx_flag) begin
          rx_in_frame_r <= 1'b1;
          rx_dly_cnt_r  <= 3'h0;
        end else if (rx_abort) begin
          rx_in_frame_r <= 1'b0;
        end else if (rx_in_frame_r && !rx_delete) begin
          rx_dly_r <= {rx_dly_r[5:0], chan_rx_bit};
          if (rx_dly_cnt_r != `HDLC_FLAG_TAIL) begin
            rx_dly_cnt_r <= rx_dly_cnt_r + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !sel) begin
      rx_len_r        <= '0;
      rx_asm_r        <= '0;
      rx_b0_r         <= '0;
      rx_b1_r         <= '0;
      rx_b2_r         <= '0;
      rx_nbytes_r     <= 2'h0;
      rx_first_pend_r <= 1'b1;
      rx_drop_r       <= 1'b0;
      rx_wr_valid_r   <= 1'b0;
      rx_wr_entry_r   <= '0;
      rx_packet_done  <= 1'b0;
      rx_bad_frame    <= 1'b0;
    end else begin
      rx_wr_valid_r  <= 1'b0;
      rx_packet_done <= 1'b0;
      rx_bad_frame   <= 1'b0;
      if (bit_step && rx_in_frame_r && (rx_flag || rx_abort)) begin
        if (rx_flag && rx_len_r >= `HDLC_MIN_KEEP_BITS) begin
          // 25 to 31 bits, or a failed check, ends bad
          rx_wr_valid_r     <= !rx_drop_r && (!rx_first_pend_r || addr_ok);
          rx_wr_entry_r.data <= rx_b2_r;
          rx_wr_entry_r.tag  <= (rx_len_r >= `HDLC_MIN_GOOD_BITS && rx_crc_ok) ?
                                RX_TAG_GOOD_END : RX_TAG_BAD_END;
          rx_packet_done    <= 1'b1;
          rx_bad_frame      <= !(rx_len_r >= `HDLC_MIN_GOOD_BITS && rx_crc_ok);
        end else if (rx_abort && rx_len_r >= `HDLC_MIN_ABORT_BITS) begin
          rx_wr_valid_r      <= !rx_drop_r && (!rx_first_pend_r || addr_ok);
          rx_wr_entry_r.data <= rx_b2_r;
          rx_wr_entry_r.tag  <= RX_TAG_BAD_END;
          rx_bad_frame       <= 1'b1;
        end else if (rx_abort) begin
          rx_bad_frame <= 1'b1;
        end
        // Short frames fall through with no write
        rx_len_r        <= '0;
        rx_nbytes_r     <= 2'h0;
        rx_first_pend_r <= 1'b1;
        rx_drop_r       <= 1'b0;
      end else if (bit_step && rx_exit) begin
        rx_len_r <= (rx_len_r == 16'hFFFF) ? rx_len_r : rx_len_r + 16'h0001;
        rx_asm_r <= asm_nxt;
        if (rx_len_r[2:0] == 3'h7) begin
          // Two-byte lag keeps the check bytes out of the FIFO
          rx_b0_r <= asm_nxt;
          rx_b1_r <= rx_b0_r;
          rx_b2_r <= rx_b1_r;
          if (rx_nbytes_r != 2'h3) begin
            rx_nbytes_r <= rx_nbytes_r + 2'h1;
          end else if (rx_len_r >= `HDLC_MIN_GOOD_BITS - 16'h0001) begin
            rx_wr_valid_r      <= !rx_drop_r && (!rx_first_pend_r || addr_ok);
            rx_wr_entry_r.data <= rx_b2_r;
            rx_wr_entry_r.tag  <= rx_first_pend_r ? RX_TAG_FIRST : RX_TAG_MID;
            rx_first_pend_r    <= 1'b0;
            if (rx_first_pend_r && !addr_ok) begin
              rx_drop_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_overflow <= 1'b0;
    end else begin
      rx_overflow <= sel && rx_wr_valid_r && !rx_wr_ready;
    end
  end
endmodule // hdlc_packet_transceiver

// ===== hdlc_defines.svh
`ifndef HDLC_DEFINES_SVH
`define HDLC_DEFINES_SVH

// ------------------------------------------------------------
// Channel placement
// ------------------------------------------------------------
`define HDLC_T1_SLOT_INDEX     5'h17
`define HDLC_E1_SLOT_INDEX     5'h10
`define HDLC_RATE56_SKIP_BIT   3'h7

// ------------------------------------------------------------
// Line patterns and counts
// ------------------------------------------------------------
`define HDLC_FLAG              8'h7E
`define HDLC_ONES_BYTE         8'hFF
`define HDLC_ABORT_BYTE        8'hFE
`define HDLC_GO_AHEAD          9'h0FE
`define HDLC_ALL_CALL          8'hFF
`define HDLC_STUFF_ONES        4'h5
`define HDLC_ABORT_ONES        4'h7
`define HDLC_IDLE_ONES         4'hF
`define HDLC_FLAG_TAIL         3'h7
`define HDLC_MIN_KEEP_BITS     16'h0019
`define HDLC_MIN_GOOD_BITS     16'h0020
`define HDLC_MIN_ABORT_BITS    16'h001A

// ------------------------------------------------------------
// Check sequence
// ------------------------------------------------------------
`define HDLC_CRC_PRESET        16'hFFFF
`define HDLC_CRC_POLY_REFL     16'h8408
`define HDLC_CRC_GOOD          16'hF0B8

// ------------------------------------------------------------
// FIFO
// ------------------------------------------------------------
`define HDLC_FIFO_DEPTH        128
`define HDLC_THR_STEP          16
`endif

// ===== hdlc_pkg.sv
package hdlc_pkg;
  typedef struct packed {
    logic       end_of_packet_tag;
    logic       abort_tag;
    logic [7:0] data;
  } tx_entry_t;

  typedef enum logic [1:0] {
    RX_TAG_MID      = 2'h0,
    RX_TAG_FIRST    = 2'h1,
    RX_TAG_GOOD_END = 2'h2,
    RX_TAG_BAD_END  = 2'h3
  } rx_tag_t;

  typedef struct packed {
    rx_tag_t    tag;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {
    TX_FILL  = 3'h0,
    TX_FLAG  = 3'h1,
    TX_DATA  = 3'h2,
    TX_FCS   = 3'h3,
    TX_ABORT = 3'h4
  } tx_state_t;
endpackage

// ===== hdlc_fifo.sv
`timescale 1ns/1ps
module hdlc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  output      logic [LVL_W-1:0] level
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2) begin : g_bad_depth
    $error("hdlc_fifo depth below 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [LVL_W-1:0] count_r;
  logic             push;
  logic             pop;

  assign in_ready  = count_r != LVL_W'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data  = mem[rd_ptr_r];
  assign level     = count_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // hdlc_fifo

// ===== hdlc_crc16.sv
`timescale 1ns/1ps
`include "hdlc_defines.svh"
module hdlc_crc16 (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic        din,
  output      logic [15:0] crc,
  output      logic [15:0] crc_nxt
);
  // Reflected form: bit 0 holds the highest-order term, so
  // shifting out from bit 0 sends the check high-order first
  logic [15:0] crc_r;

  assign crc     = crc_r;
  assign crc_nxt = (crc_r >> 1) ^ ((crc_r[0] ^ din) ? `HDLC_CRC_POLY_REFL : 16'h0000);

  always_ff @(posedge clk) begin
    if (srst || clear) begin
      crc_r <= `HDLC_CRC_PRESET;
    end else if (step) begin
      crc_r <= crc_nxt;
    end
  end
endmodule // hdlc_crc16

// ===== hdlc_chk_checker.sv
`timescale 1ns/1ps
module hdlc_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       second_packet_controller_select,
  input wire logic       channel_rate_select,
  input wire logic       e1_mode,
  input wire logic       ts16_alarm_detect,
  input wire logic       ts16_alarm_force_transmit,
  input wire logic       chan_strobe,
  input wire logic [4:0] chan_slot,
  input wire logic [2:0] chan_bit,
  input wire logic       chan_tx_bit,
  input wire logic       chan_tx_drive,
  input wire logic       ts16_alarm_status
);
  wire sel = second_packet_controller_select;
  wire frc = ts16_alarm_force_transmit;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Channel slot timing and alarm status
  // ----
  sequence t1_slot;
    chan_strobe && sel && !e1_mode && chan_slot == 5'h17;
  endsequence
  sequence force_slot;
    chan_strobe && sel && e1_mode && frc && chan_slot == 5'h10;
  endsequence
  a_t1_drive: assert property (t1_slot ##0 (channel_rate_select || chan_bit != 3'h7)
    |=> chan_tx_drive) else $error("own slot bit not driven");
  a_skip_56k: assert property (t1_slot ##0 (!channel_rate_select && chan_bit == 3'h7)
    |=> !chan_tx_drive) else $error("skipped bit driven at 56k");
  a_wrong_slot: assert property (chan_strobe && !e1_mode && chan_slot != 5'h17
    |=> !chan_tx_drive) else $error("foreign slot driven");
  a_drive_cause: assert property (chan_tx_drive |-> $past(chan_strobe))
    else $error("drive without strobe");
  a_drive_pulse: assert property (chan_tx_drive |=> !chan_tx_drive)
    else $error("drive longer than one cycle");
  a_off_quiet: assert property (!$past(sel) && !$past(frc) |-> !chan_tx_drive)
    else $error("deselected controller drives");
  a_force_ones: assert property (force_slot |=> chan_tx_drive && chan_tx_bit)
    else $error("forced alarm ones missing");
  a_alarm_copy: assert property (!$past(srst) |-> ts16_alarm_status == $past(ts16_alarm_detect))
    else $error("alarm status not following");
endmodule // hdlc_chk

bind hdlc_packet_transceiver hdlc_chk u_chk (.clk(clk), .srst(srst),
  .second_packet_controller_select(second_packet_controller_select),
  .channel_rate_select(channel_rate_select), .e1_mode(e1_mode),
  .ts16_alarm_detect(ts16_alarm_detect), .ts16_alarm_force_transmit(ts16_alarm_force_transmit),
  .chan_strobe(chan_strobe), .chan_slot(chan_slot), .chan_bit(chan_bit),
  .chan_tx_bit(chan_tx_bit), .chan_tx_drive(chan_tx_drive), .ts16_alarm_status(ts16_alarm_status));

// ===== hdlc_chan_model.sv
`timescale 1ns/1ps
module hdlc_chan_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [4:0] slot_sel,
  input  wire logic       chan_tx_bit,
  input  wire logic       chan_tx_drive,
  output      logic       chan_strobe,
  output      logic [4:0] chan_slot,
  output      logic [2:0] chan_bit,
  output      logic       chan_rx_bit
);
  // ----
  // Free-running framer, line looped back
  // ----
  logic [4:0] cnt_r;
  wire        foreign = cnt_r[4:2] == 3'h7;
  assign chan_strobe = cnt_r[1:0] == 2'h0 && !srst;
  // One strobe in eight goes elsewhere, so slot decoding is exercised
  assign chan_slot = foreign ? 5'h00 : slot_sel;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r    <= 5'h00;
      chan_bit <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      if (chan_strobe && !foreign) chan_bit <= chan_bit + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) chan_rx_bit <= 1'b1;
    else if (chan_tx_drive) chan_rx_bit <= chan_tx_bit;
  end
endmodule // hdlc_chan_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top import hdlc_pkg::*; ;
  logic clk = 1'b0, srst = 1'b1, second_packet_controller_select = 1'b1;
  logic channel_rate_select = 1'b1, e1_mode = 1'b0, ccs_mode = 1'b0, idle_select_flags = 1'b0;
  logic ts16_alarm_detect = 1'b0, ts16_alarm_force_transmit = 1'b0, tx_wr_valid = 1'b0;
  logic rx_rd_ready = 1'b0, chan_strobe, chan_rx_bit, chan_tx_bit, chan_tx_drive, tx_wr_ready;
  logic rx_rd_valid, ts16_alarm_status, tx_underrun, tx_packet_done, rx_bad_frame, rx_idle;
  logic rx_go_ahead, tx_fifo_low, addr_match_enable = 1'b0;
  logic [2:0] fifo_threshold = 3'h0;
  logic [4:0] chan_slot, slot_sel = 5'h17;
  logic [2:0] chan_bit;
  tx_entry_t  tx_wr_entry = '0;
  rx_entry_t  rx_rd_entry, e;
  int         err_total = 0, checked = 0, n, k, ga = 0, bf = 0;

  always #5 clk = ~clk;

  hdlc_packet_transceiver #(.FIFO_DEPTH(32)) DUT (
    .clk, .srst, .second_packet_controller_select, .channel_rate_select, .e1_mode, .ccs_mode,
    .idle_select_flags, .ts16_alarm_detect, .ts16_alarm_force_transmit,
    .addr_match_enable, .addr_two_byte(1'b0), .addr_first(8'h00), .addr_second(8'h00),
    .fifo_threshold, .chan_strobe, .chan_slot, .chan_bit, .chan_rx_bit, .chan_tx_bit,
    .chan_tx_drive, .tx_wr_valid, .tx_wr_entry, .tx_wr_ready, .rx_rd_valid, .rx_rd_entry,
    .rx_rd_ready, .ts16_alarm_status, .tx_fifo_low, .rx_fifo_high(), .tx_underrun,
    .tx_packet_done, .rx_packet_done(), .rx_bad_frame, .rx_overflow(), .rx_go_ahead, .rx_idle);
  hdlc_chan_model u_chan (.clk, .srst, .slot_sel, .chan_tx_bit, .chan_tx_drive, .chan_strobe,
    .chan_slot, .chan_bit, .chan_rx_bit);

  // Event pulses are counted so scenarios can judge them afterwards
  always @(posedge clk) begin
    ga += int'(rx_go_ahead === 1'b1);
    bf += int'(rx_bad_frame === 1'b1);
  end

  // ----
  // Helpers
  // ----
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task do_reset;
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
  endtask
  task send(input logic [7:0] q[$], input logic eop, input logic ab);
    foreach (q[i]) begin
      tx_wr_entry = {eop && i == q.size() - 1, ab && i == q.size() - 1, q[i]};
      tx_wr_valid = 1'b1;
      n = 0;
      // Ready is judged before the taking edge, so no entry is written twice
      while (tx_wr_ready !== 1'b1 && n < 500) begin tick(1); n++; end
      tick(1);
    end
    tx_wr_valid = 1'b0;
  endtask
  task rd(output rx_entry_t x);
    n = 0;
    while (rx_rd_valid !== 1'b1 && n < 3000) begin tick(1); n++; end
    x = rx_rd_entry;
    rx_rd_ready = 1'b1;
    tick(1);
    rx_rd_ready = 1'b0;
    tick(1);
  endtask
  task wait_flag(input int which);
    k = 0;
    while ((which ? tx_underrun : tx_packet_done) !== 1'b1 && k < 3000) begin tick(1); k++; end
  endtask

  // ----
  // Scenarios
  // ----
  task t_good;
    logic [7:0] q[$];
    q = '{8'hAA, 8'hFF, 8'h7E, 8'h03};
    send(q, 1'b1, 1'b0);
    foreach (q[i]) begin
      rd(e);
      chk(e, {i == 0 ? RX_TAG_FIRST : i == 3 ? RX_TAG_GOOD_END : RX_TAG_MID, q[i]});
    end
  endtask
  task t_idle;
    k = 0;
    while (rx_idle !== 1'b1 && k < 600) begin tick(1); k++; end
    chk(rx_idle, 1'b1);
    chk(tx_fifo_low, 1'b1);
    idle_select_flags = 1'b1;
    tick(300);
    chk(rx_idle, 1'b0);
  endtask
  task t_short;
    int b;
    b = bf;
    channel_rate_select = 1'b0;
    send('{8'h5A}, 1'b1, 1'b0);
    wait_flag(0);
    tick(300);
    chk(rx_rd_valid, 1'b0);
    chk(10'(bf - b), 10'h000);
  endtask
  task t_addr;
    addr_match_enable = 1'b1;
    send('{8'hAA, 8'h01, 8'h02, 8'h03}, 1'b1, 1'b0);
    wait_flag(0);
    tick(300);
    chk(rx_rd_valid, 1'b0);
    send('{8'hFF, 8'h01, 8'h02}, 1'b1, 1'b0);
    rd(e);
    chk(e, {RX_TAG_FIRST, 8'hFF});
    rd(e);
    rd(e);
    chk(e, {RX_TAG_GOOD_END, 8'h02});
    addr_match_enable = 1'b0;
  endtask
  task t_abort;
    send('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 1'b0, 1'b1);
    rd(e);
    chk(e, {RX_TAG_FIRST, 8'h11});
    k = 0;
    while (e.tag !== RX_TAG_BAD_END && k < 4) begin rd(e); k++; end
    chk({8'h00, e.tag}, {8'h00, RX_TAG_BAD_END});
    tick(20);
    chk(ga != 0, 1'b1);
  endtask
  task t_underrun;
    int b;
    b = bf;
    send('{8'hC3}, 1'b0, 1'b0);
    wait_flag(1);
    chk(tx_underrun, 1'b1);
    tick(300);
    chk(rx_rd_valid, 1'b0);
    chk(bf != b, 1'b1);
  endtask
  task t_ts16;
    e1_mode = 1'b1;
    ccs_mode = 1'b1;
    slot_sel = 5'h10;
    ts16_alarm_force_transmit = 1'b1;
    ts16_alarm_detect = 1'b1;
    tick(200);
    chk(ts16_alarm_status, 1'b1);
    k = 0;
    while (chan_tx_drive !== 1'b1 && k < 50) begin tick(1); k++; end
    chk(chan_tx_bit, 1'b1);
    {e1_mode, ccs_mode, ts16_alarm_force_transmit, ts16_alarm_detect} = 4'h0;
    slot_sel = 5'h17;
  endtask
  task t_fill;
    second_packet_controller_select = 1'b0;
    tick(2);
    k = 0;
    tx_wr_valid = 1'b1;
    while (tx_wr_ready === 1'b1 && k < 40) begin tick(1); k++; end
    tx_wr_valid = 1'b0;
    chk(10'(k), 10'h020);
    chk(tx_fifo_low, 1'b0);
    second_packet_controller_select = 1'b1;
    do_reset;
  endtask

  task stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    do_reset;
    t_good;
    t_idle;
    t_short;
    t_addr;
    t_abort;
    t_underrun;
    t_ts16;
    t_fill;
    stop_test;
  end
  // Whole run needs well under 30000 cycles
  initial begin
    #300000;
    err_total++;
    stop_test;
  end
endmodule // tb_top
